/* pkg/sfs_consts.svh */
// opcodes, status layout, frame lengths and timing counts of the serial flash status block
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

`define SFS_OP_WR_EN        8'h06
`define SFS_OP_WR_DIS       8'h04
`define SFS_OP_STAT_RD      8'h05
`define SFS_OP_STAT_WR      8'h01
`define SFS_OP_READ         8'h03
`define SFS_OP_FAST_READ    8'h0b
`define SFS_OP_CHIP_ERA_A   8'hc7
`define SFS_OP_CHIP_ERA_B   8'h60
`define SFS_OP_EXT_ENTER    8'h0a
`define SFS_OP_OTP_ENTER    8'h3a
`define SFS_OP_DUAL_ENTER   8'h38
`define SFS_OP_SINGLE_ENTER 8'hff

`define SFS_ST_BUSY         0
`define SFS_ST_WEL          1
`define SFS_ST_BP_LSB       2
`define SFS_ST_BP_MSB       4
`define SFS_ST_SRP          7

`define SFS_MODE_SINGLE     2'h0
`define SFS_MODE_DUAL       2'h1
`define SFS_BP_RESET        3'h0
`define SFS_SRP_RESET       1'h0

`define SFS_CNT_ONE_BYTE    6'h08
`define SFS_CNT_TWO_BYTE    6'h10
`define SFS_CNT_OP_LAST     6'h07
`define SFS_CNT_DAT_LAST    6'h0f
`define SFS_CNT_ADDR_LAST   6'h1f
`define SFS_CNT_SAT         6'h3f
`define SFS_DUM_LAST_SINGLE 3'h7
`define SFS_DUM_LAST_DUAL   3'h3

`define SFS_CLK_MHZ         125
`define SFS_TW_NS           10000
`define SFS_TW_CYC          ((`SFS_TW_NS * `SFS_CLK_MHZ + 999) / 1000)
`define SFS_TW_W            11

`endif

/* pkg/sfs_pkg.sv */
// state and mode types of the serial flash status block
package sfs_pkg;

  typedef enum logic [2:0] {
    lk_opcode,
    lk_addr,
    lk_dummy,
    lk_data,
    lk_status,
    lk_cmd,
    lk_ignore
  } sfs_link_st_t;

  typedef enum logic [1:0] {
    xm_normal,
    xm_ext,
    xm_otp
  } sfs_xmode_t;

endpackage

/* logic/sfs_flash_ctrl.sv */
// serial flash command logic: write-enable latch, status register, array reads
`timescale 1ns/10ps
`include "sfs_consts.svh"

module sfs_flash_ctrl (
  input  wire logic        clk,                 // core clock, 125 MHz
  input  wire logic        rst_b,               // async reset, active low
  input  wire logic        spi_sclk,            // serial clock from host
  input  wire logic        spi_cs_b,            // chip select, active low
  input  wire logic        spi_di,              // serial data in
  output logic             spi_do_o,            // serial data out
  output logic             spi_do_oe_b,         // data out enable, low drives
  input  wire logic        wp_b,                // write-protect pin, active low
  output logic [23:0]      arr_addr,            // array read address, sclk domain
  input  wire logic [7:0]  arr_rdata,           // array read data, sclk domain
  input  wire logic        ext_busy,            // program/erase engine running
  input  wire logic        ext_done,            // program/erase engine finished
  output logic             chip_erase_req,      // one-cycle chip erase start
  output logic [2:0]       block_protect_bits,  // protected region select
  output logic [1:0]       interface_mode_bits, // 00 single, 01 dual
  output logic             otp_lock             // otp sector locked
);

  // ---------------- link side (spi_sclk) ----------------
  // frame state resets while deselected; captured fields survive for the core
  wire                  link_clr_b = rst_b & ~spi_cs_b;

  logic                 in_frame_r;
  sfs_pkg::sfs_link_st_t lk_st_r;
  sfs_pkg::sfs_link_st_t lk_st_nxt;
  logic [2:0]           dcnt_r;
  logic [6:0]           sh_r;
  logic [5:0]           cnt_r;
  logic [7:0]           op_r;
  logic [7:0]           dat_r;
  logic [23:0]          addr_r;
  logic                 frm_tgl_r;
  logic [7:0]           stat_s1_r;
  logic [7:0]           stat_s2_r;
  logic [2:0]           ob_cnt_r;
  logic [6:0]           osh_r;
  logic                 do_r;
  logic [7:0]           stat_r;
  logic [1:0]           mode_r;

  wire [7:0]  opcode_w  = {sh_r, spi_di};
  wire        busy_s    = stat_s2_r[`SFS_ST_BUSY];
  wire        is_read_w = (opcode_w == `SFS_OP_READ) || (opcode_w == `SFS_OP_FAST_READ);
  wire        op_end    = in_frame_r && (lk_st_r == sfs_pkg::lk_opcode)
                          && (cnt_r == `SFS_CNT_OP_LAST);
  wire [5:0]  cnt_nxt   = !in_frame_r ? 6'h01 :
                          (cnt_r == `SFS_CNT_SAT) ? cnt_r : cnt_r + 6'h01;
  wire        out_act   = (lk_st_r == sfs_pkg::lk_data) || (lk_st_r == sfs_pkg::lk_status);
  wire        streaming = (lk_st_r == sfs_pkg::lk_dummy) || (lk_st_r == sfs_pkg::lk_data);
  wire [7:0]  out_byte  = (lk_st_r == sfs_pkg::lk_status) ? stat_s2_r : arr_rdata;
  logic [1:0] mode_s_r;
  wire [2:0]  dum_last  = (mode_s_r == `SFS_MODE_DUAL) ? `SFS_DUM_LAST_DUAL
                                                       : `SFS_DUM_LAST_SINGLE;

  always_comb begin
    lk_st_nxt = lk_st_r;
    case (lk_st_r)
      sfs_pkg::lk_opcode: begin
        if (op_end) begin
          if (opcode_w == `SFS_OP_STAT_RD) begin
            lk_st_nxt = sfs_pkg::lk_status;
          end else if (is_read_w) begin
            lk_st_nxt = busy_s ? sfs_pkg::lk_ignore : sfs_pkg::lk_addr;
          end else begin
            lk_st_nxt = sfs_pkg::lk_cmd;
          end
        end
      end
      sfs_pkg::lk_addr: begin
        if (cnt_r == `SFS_CNT_ADDR_LAST) begin
          lk_st_nxt = (op_r == `SFS_OP_FAST_READ) ? sfs_pkg::lk_dummy : sfs_pkg::lk_data;
        end
      end
      sfs_pkg::lk_dummy: begin
        if (dcnt_r == dum_last) begin
          lk_st_nxt = sfs_pkg::lk_data;
        end
      end
      default: lk_st_nxt = lk_st_r;
    endcase
  end

  always_ff @(posedge spi_sclk or negedge link_clr_b) begin
    if (!link_clr_b) begin
      in_frame_r <= 1'b0;
      lk_st_r    <= sfs_pkg::lk_opcode;
      dcnt_r     <= 3'h0;
    end else begin
      in_frame_r <= 1'b1;
      lk_st_r    <= lk_st_nxt;
      // restart on entering data so byte bounds hold after four dummies
      dcnt_r     <= (streaming && lk_st_nxt == lk_st_r) ? dcnt_r + 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      sh_r      <= 7'h00;
      cnt_r     <= 6'h00;
      frm_tgl_r <= 1'b0;
    end else begin
      sh_r      <= in_frame_r ? {sh_r[5:0], spi_di} : {6'h00, spi_di};
      cnt_r     <= cnt_nxt;
      frm_tgl_r <= in_frame_r ? frm_tgl_r : ~frm_tgl_r;
    end
  end

  // opcode and data byte stay put after deselect
  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      op_r  <= 8'h00;
      dat_r <= 8'h00;
    end else begin
      op_r  <= op_end ? opcode_w : op_r;
      dat_r <= (lk_st_r == sfs_pkg::lk_cmd && cnt_r == `SFS_CNT_DAT_LAST) ? opcode_w : dat_r;
    end
  end

  // increment after each byte, 24-bit wrap
  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r <= 24'h000000;
    end else if (lk_st_r == sfs_pkg::lk_addr) begin
      addr_r <= {addr_r[22:0], spi_di};
    end else if (lk_st_r == sfs_pkg::lk_data && dcnt_r == 3'h7) begin
      addr_r <= addr_r + 24'h000001;
    end
  end

  // status seen by the link; needs two sclk edges, opcode gives eight
  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      stat_s1_r <= 8'h00;
      stat_s2_r <= 8'h00;
    end else begin
      stat_s1_r <= stat_r;
      stat_s2_r <= stat_s1_r;
    end
  end

  logic [1:0] mode_s1_r;
  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_s1_r <= `SFS_MODE_SINGLE;
      mode_s_r  <= `SFS_MODE_SINGLE;
    end else begin
      mode_s1_r <= mode_r;
      mode_s_r  <= mode_s1_r;
    end
  end

  // data shifted out on falling edges; status byte reloads every byte
  always_ff @(negedge spi_sclk or negedge link_clr_b) begin
    if (!link_clr_b) begin
      ob_cnt_r <= 3'h0;
      osh_r    <= 7'h00;
      do_r     <= 1'b0;
    end else if (out_act) begin
      ob_cnt_r <= ob_cnt_r + 3'h1;
      osh_r    <= (ob_cnt_r == 3'h0) ? out_byte[6:0] : {osh_r[5:0], 1'b0};
      do_r     <= (ob_cnt_r == 3'h0) ? out_byte[7] : osh_r[6];
    end
  end

  assign spi_do_o    = do_r;
  assign spi_do_oe_b = ~(out_act & ~spi_cs_b);
  assign arr_addr    = addr_r;

  // ---------------- core side (clk) ----------------
  logic       cs_s1_r, cs_s2_r, cs_s3_r;
  logic       tgl_s1_r, tgl_s2_r, tgl_seen_r;
  logic       wp_s1_r, wp_s2_r;
  logic       wel_r, wel_nxt;
  logic       srp_r;
  logic [2:0] bp_r;
  sfs_pkg::sfs_xmode_t xm_r;
  logic       wcyc_r;
  logic [`SFS_TW_W-1:0] wcnt_r;
  logic       ce_req_r;
  logic       otp_lock_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1_r    <= 1'b1;
      cs_s2_r    <= 1'b1;
      cs_s3_r    <= 1'b1;
      tgl_s1_r   <= 1'b0;
      tgl_s2_r   <= 1'b0;
      tgl_seen_r <= 1'b0;
      wp_s1_r    <= 1'b1;
      wp_s2_r    <= 1'b1;
    end else begin
      cs_s1_r    <= spi_cs_b;
      cs_s2_r    <= cs_s1_r;
      cs_s3_r    <= cs_s2_r;
      tgl_s1_r   <= frm_tgl_r;
      tgl_s2_r   <= tgl_s1_r;
      tgl_seen_r <= cs_s2_r ? tgl_s2_r : tgl_seen_r;
      wp_s1_r    <= wp_b;
      wp_s2_r    <= wp_s1_r;
    end
  end

  // a frame with clocks ended; link fields are quiet while deselected
  wire frame_end = cs_s2_r & ~cs_s3_r & (tgl_s2_r != tgl_seen_r);
  wire one_byte  = frame_end & (cnt_r == `SFS_CNT_ONE_BYTE);
  wire busy      = wcyc_r | ext_busy;
  wire hardware_protected_mode       = srp_r & ~wp_s2_r;
  wire is_otp    = (xm_r == sfs_pkg::xm_otp);
  wire cmd_write_enable_cmd  = one_byte & (op_r == `SFS_OP_WR_EN);
  wire cmd_write_disable_cmd  = one_byte & (op_r == `SFS_OP_WR_DIS);
  wire cmd_ext   = one_byte & (op_r == `SFS_OP_EXT_ENTER);
  wire cmd_otp   = one_byte & (op_r == `SFS_OP_OTP_ENTER);
  wire cmd_dual  = one_byte & (op_r == `SFS_OP_DUAL_ENTER);
  wire cmd_sngl  = one_byte & (op_r == `SFS_OP_SINGLE_ENTER);
  // latch and hardware protection gate the write
  wire wsr_go    = frame_end & (cnt_r == `SFS_CNT_TWO_BYTE) & (op_r == `SFS_OP_STAT_WR)
                   & wel_r & ~busy & ~hardware_protected_mode;
  // chip erase only with no protected blocks
  wire ce_go     = one_byte & ((op_r == `SFS_OP_CHIP_ERA_A) | (op_r == `SFS_OP_CHIP_ERA_B))
                   & wel_r & ~busy & (bp_r == 3'h0);
  wire wcyc_done = wcyc_r & (wcnt_r == `SFS_TW_W'(1));
  // write disable leaves a special mode, else clears the latch
  wire wel_clr   = (cmd_write_disable_cmd & (xm_r == sfs_pkg::xm_normal)) | wcyc_done | ext_done;

  // set wins over any same-cycle clear
  assign wel_nxt = cmd_write_enable_cmd | (wel_r & ~wel_clr);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wel_r <= 1'b0;
    end else begin
      wel_r <= wel_nxt;
    end
  end

  // self-timed status write cycle of tW
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wcyc_r <= 1'b0;
      wcnt_r <= '0;
    end else if (wsr_go) begin
      wcyc_r <= 1'b1;
      wcnt_r <= `SFS_TW_W'(`SFS_TW_CYC);
    end else if (wcyc_r) begin
      wcyc_r <= ~wcyc_done;
      wcnt_r <= wcnt_r - `SFS_TW_W'(1);
    end
  end

  // only protect fields change; otp write only sets the lock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bp_r  <= `SFS_BP_RESET;
      srp_r <= `SFS_SRP_RESET;
    end else if (wsr_go) begin
      bp_r  <= is_otp ? bp_r : dat_r[`SFS_ST_BP_MSB:`SFS_ST_BP_LSB];
      srp_r <= is_otp ? 1'b1 : dat_r[`SFS_ST_SRP];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= `SFS_MODE_SINGLE;
      xm_r   <= sfs_pkg::xm_normal;
    end else begin
      mode_r <= cmd_dual ? `SFS_MODE_DUAL : (cmd_sngl ? `SFS_MODE_SINGLE : mode_r);
      xm_r   <= cmd_ext ? sfs_pkg::xm_ext : cmd_otp ? sfs_pkg::xm_otp :
                cmd_write_disable_cmd ? sfs_pkg::xm_normal : xm_r;
    end
  end

  // busy and latch mirrored; S6 S5 read zero
  wire [7:0] stat_nxt = {srp_r, 2'b00, bp_r, wel_r, busy};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r     <= 8'h00;
      ce_req_r   <= 1'b0;
      otp_lock_r <= 1'b0;
    end else begin
      stat_r     <= stat_nxt;
      ce_req_r   <= ce_go;
      // locked otp sector refuses program and erase
      otp_lock_r <= is_otp & srp_r;
    end
  end

  assign chip_erase_req      = ce_req_r;
  assign block_protect_bits  = bp_r;
  assign interface_mode_bits = mode_r;
  assign otp_lock            = otp_lock_r;

  // ---------------- checks ----------------
  logic [`SFS_TW_W-1:0] blen_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blen_r <= '0;
    end else begin
      blen_r <= wsr_go ? '0 : (wcyc_r ? blen_r + `SFS_TW_W'(1) : blen_r);
    end
  end

  write_enable_cmd_sets_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_write_enable_cmd |=> wel_r ##1 stat_r[`SFS_ST_WEL])
    else $error("write enable did not set the latch");

  write_disable_cmd_clears_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_write_disable_cmd && xm_r == sfs_pkg::xm_normal |=> !wel_r)
    else $error("write disable left the latch set");

  busy_length_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(wcyc_r) |-> blen_r == `SFS_TW_W'(`SFS_TW_CYC))
    else $error("status write cycle length wrong");

  cycle_end_wel_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(wcyc_r) |-> !wel_r || $past(cmd_write_enable_cmd))
    else $error("latch survived end of write cycle");

  status_write_cmd_no_wel_a: assert property (@(posedge clk) disable iff (!rst_b)
    frame_end && op_r == `SFS_OP_STAT_WR && !wel_r && !wcyc_r
    |=> !wcyc_r && $stable(bp_r) && $stable(srp_r))
    else $error("status write ran without latch");

  hpm_locks_a: assert property (@(posedge clk) disable iff (!rst_b)
    frame_end && hardware_protected_mode |=> $stable(bp_r) && $stable(srp_r))
    else $error("protected status bits changed");

  erase_bp_a: assert property (@(posedge clk) disable iff (!rst_b)
    chip_erase_req |-> bp_r == 3'h0 && $past(wel_r))
    else $error("chip erase with protected blocks");

  otp_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    wsr_go && is_otp |=> srp_r && $stable(bp_r) && wcyc_r)
    else $error("otp status write did not lock");

  status_write_cmd_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    frame_end && op_r == `SFS_OP_STAT_WR && cnt_r != `SFS_CNT_TWO_BYTE && !wcyc_r
    |=> !wcyc_r [*2])
    else $error("status write ran on a bad frame");

  read_reject_a: assert property (@(posedge spi_sclk) disable iff (!link_clr_b)
    op_end && is_read_w && busy_s |=> lk_st_r == sfs_pkg::lk_ignore [*2])
    else $error("read accepted while busy");

  wsr_cycle_c: cover property (@(posedge clk) disable iff (!rst_b) $fell(wcyc_r));
  chip_erase_c: cover property (@(posedge clk) disable iff (!rst_b) chip_erase_req);
  fast_data_c: cover property (@(posedge spi_sclk) disable iff (!link_clr_b)
    lk_st_r == sfs_pkg::lk_dummy ##1 lk_st_r == sfs_pkg::lk_data);
  stat_rd_c: cover property (@(posedge spi_sclk) disable iff (!link_clr_b)
    lk_st_r == sfs_pkg::lk_status && dcnt_r == 3'h0 && cnt_r > 6'h10);

endmodule

/* sim/sfs_host_model.sv */
// host-side serial flash controller model: frames commands and samples data out
`timescale 1ns/10ps

module sfs_host_model (
  output logic      spi_sclk,    // serial clock, still low outside frames
  output logic      spi_cs_b,    // chip select, active low
  output logic      spi_di,      // serial data to the device
  input  wire logic spi_do_o,    // serial data from the device
  input  wire logic spi_do_oe_b  // device drive enable, low drives
);
  int oe_cnt;  // rising edges of the last frame with data out driven

  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_di   = 1'b0;
    oe_cnt   = 0;
  end

  // msb first, exact bit count, 30 ns sclk
  // cs rises right after the last bit sent
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    int i;
    rx = 64'h0;
    oe_cnt = 0;
    spi_cs_b = 1'b0;
    for (i = 0; i < n; i++) begin
      spi_di = tx[63-i];
      #15;
      rx[63-i] = spi_do_o;
      if (spi_do_oe_b === 1'b0) oe_cnt++;
      spi_sclk = 1'b1;
      #15;
      spi_sclk = 1'b0;
    end
    #15;
    spi_cs_b = 1'b1;
    // released line shows the inverse, never a held value
    spi_di = ~spi_di;
    // cs high far beyond four core clocks so the core sees the rise
    #120;
  endtask
endmodule

/* sim/test_sfs_flash_ctrl.sv */
// self-checking bench of the serial flash command logic
`timescale 1ns/10ps
`include "sfs_consts.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module test_sfs_flash_ctrl;
  logic        clk, rst_b, wp_b, ext_busy, ext_done;
  logic        spi_sclk, spi_cs_b, spi_di, spi_do_o, spi_do_oe_b;
  logic        chip_erase_req, otp_lock;
  logic [23:0] arr_addr;
  logic [7:0]  arr_rdata, st;
  logic [2:0]  block_protect_bits;
  logic [1:0]  interface_mode_bits;
  logic [63:0] rx;
  int          failures, tests_run, ce_cnt;

  // array content is a fixed function of the address
  assign arr_rdata = arr_addr[7:0] ^ 8'h5a;

  sfs_flash_ctrl uut (.clk(clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
    .spi_di(spi_di), .spi_do_o(spi_do_o), .spi_do_oe_b(spi_do_oe_b), .wp_b(wp_b),
    .arr_addr(arr_addr), .arr_rdata(arr_rdata), .ext_busy(ext_busy), .ext_done(ext_done),
    .chip_erase_req(chip_erase_req), .block_protect_bits(block_protect_bits),
    .interface_mode_bits(interface_mode_bits), .otp_lock(otp_lock));

  sfs_host_model host (.spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_di(spi_di),
    .spi_do_o(spi_do_o), .spi_do_oe_b(spi_do_oe_b));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (chip_erase_req === 1'b1) ce_cnt <= ce_cnt + 1;
  end

  task automatic final_report;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op, input int n = 8);
    host.frame({op, 56'h0}, n, rx);
  endtask

  // second byte is judged: the first bits may be stale right after a change
  task automatic st_rd;
    host.frame({`SFS_OP_STAT_RD, 56'h0}, 24, rx);
    st = rx[47:40];
  endtask

  task automatic status_write_cmd(input logic [7:0] d, input int n = 16);
    host.frame({`SFS_OP_STAT_WR, d, 48'h0}, n, rx);
  endtask

  task automatic wait_idle;
    int k;
    for (k = 0; k < 40; k++) begin
      st_rd();
      if (st[0] === 1'b0) break;
    end
    `CHK("busy_end", 1'b0, st[0])
  endtask

  task automatic t_reset;
    st_rd();
    `CHK("status_rst", 8'h00, st)
    `CHK("mode_rst", 2'h0, interface_mode_bits)
  endtask

  task automatic t_latch;
    cmd(`SFS_OP_WR_EN);
    st_rd();
    `CHK("write_enable_cmd", 8'h02, st)
    cmd(`SFS_OP_WR_DIS);
    st_rd();
    `CHK("write_disable_cmd", 8'h00, st)
    cmd(`SFS_OP_WR_EN, 9);
    st_rd();
    `CHK("write_enable_cmd_9bit", 8'h00, st)
    status_write_cmd(8'h9c);
    st_rd();
    `CHK("status_write_cmd_no_wel", 8'h00, st)
    `CHK("bp_no_wel", 3'h0, block_protect_bits)
    cmd(`SFS_OP_EXT_ENTER);
    cmd(`SFS_OP_WR_EN);
    cmd(`SFS_OP_WR_DIS);
    st_rd();
    `CHK("write_disable_cmd_ext", 8'h02, st)
    cmd(`SFS_OP_WR_DIS);
    st_rd();
    `CHK("write_disable_cmd_norm", 8'h00, st)
  endtask

  task automatic t_status_write_cmd;
    cmd(`SFS_OP_WR_EN);
    status_write_cmd(8'hff, 17);
    st_rd();
    `CHK("status_write_cmd_17bit", 8'h02, st)
    status_write_cmd(8'hff);
    host.frame({`SFS_OP_STAT_RD, 56'h0}, 24, rx);
    `CHK("stat_busy", 8'h9f, rx[47:40])
    `CHK("stat_repeat", 8'h9f, rx[55:48])
    host.frame({`SFS_OP_READ, 24'h000100, 32'h0}, 48, rx);
    `CHK("read_busy_oe", 0, host.oe_cnt)
    st_rd();
    `CHK("busy_kept", 1'b1, st[0])
    wait_idle();
    `CHK("status_write_cmd_end", 8'h9c, st)
    `CHK("bp_out", 3'h7, block_protect_bits)
  endtask

  task automatic t_hpm;
    logic [7:0] ops[2];
    int k;
    ops = '{`SFS_OP_CHIP_ERA_A, `SFS_OP_CHIP_ERA_B};
    @(posedge clk) wp_b <= 1'b0;
    cmd(`SFS_OP_WR_EN);
    status_write_cmd(8'h00);
    st_rd();
    `CHK("hpm_status_write_cmd", 8'h9e, st)
    cmd(`SFS_OP_CHIP_ERA_A);
    `CHK("ce_bp_set", 0, ce_cnt)
    @(posedge clk) wp_b <= 1'b1;
    status_write_cmd(8'h00);
    wait_idle();
    `CHK("bp_clear", 8'h00, st)
    for (k = 0; k < 2; k++) begin
      cmd(`SFS_OP_WR_EN);
      cmd(ops[k]);
      `CHK("ce_ok", k + 1, ce_cnt)
    end
  endtask

  task automatic t_engine;
    @(posedge clk) ext_busy <= 1'b1;
    st_rd();
    `CHK("ext_busy", 8'h03, st)
    @(posedge clk) ext_done <= 1'b1;
    @(posedge clk) ext_done <= 1'b0;
    ext_busy <= 1'b0;
    st_rd();
    `CHK("ext_done", 8'h00, st)
  endtask

  task automatic t_read;
    host.frame({`SFS_OP_READ, 24'hfffffe, 32'h0}, 56, rx);
    `CHK("read_wrap", 24'ha4a55a, rx[31:8])
    `CHK("read_oe", 24, host.oe_cnt)
    host.frame({`SFS_OP_FAST_READ, 24'h000010, 32'h0}, 56, rx);
    `CHK("fast_single", 16'h4a4b, rx[23:8])
    cmd(`SFS_OP_DUAL_ENTER);
    `CHK("mode_dual", 2'h1, interface_mode_bits)
    host.frame({`SFS_OP_FAST_READ, 24'h000010, 32'h0}, 52, rx);
    `CHK("fast_dual", 16'h4a4b, rx[27:12])
    cmd(`SFS_OP_SINGLE_ENTER);
    `CHK("mode_single", 2'h0, interface_mode_bits)
  endtask

  // bp already clear before otp entry, lock before leaving
  task automatic t_otp;
    cmd(`SFS_OP_OTP_ENTER);
    cmd(`SFS_OP_WR_EN);
    status_write_cmd(8'h1c);
    wait_idle();
    `CHK("otp_status_write_cmd", 8'h80, st)
    `CHK("otp_lock", 1'b1, otp_lock)
    cmd(`SFS_OP_WR_DIS);
    `CHK("otp_exit", 1'b0, otp_lock)
  endtask

  initial begin
    #500us;
    failures++;
    final_report();
  end

  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    ext_busy = 1'b0;
    ext_done = 1'b0;
    failures = 0;
    tests_run = 0;
    ce_cnt = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_latch();
    t_status_write_cmd();
    t_hpm();
    t_engine();
    t_read();
    t_otp();
    final_report();
  end
endmodule
